// ===== inc/rst_seq_pkg.sv
// Purpose: shared constants and carriers for the reset sequencer
// Assumes: 40 MHz internal bus clock, 13-bit core address space
// Notes: offsets are byte addresses on the plain register port
package rst_seq_pkg;

	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int POR_CYCLES = 4064;
	localparam logic [2:0] PULL_CYCLES = 3'h4;
	localparam int USB_BIT_NS = 667;
	localparam int SE0_MIN_BITS = 4;
	localparam int SE0_CYCLES = (SE0_MIN_BITS * USB_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register map
	localparam logic [12:0] WDOG_SERVICE_ADDR = 13'h1FF0;
	localparam logic [12:0] CAUSE_ADDR = 13'h0019;
	localparam int WDOG_CLR_BIT = 0;

	// Memory map used by the illegal fetch check
	localparam logic [12:0] ROM_LO = 13'h1000;
	localparam logic [12:0] RAM_LO = 13'h0080;
	localparam logic [12:0] RAM_HI = 13'h012F;
	localparam logic [12:0] VEC_ADDR = 13'h1FFE;

	// Reset cause register fields
	localparam int CAUSE_PIN = 0;
	localparam int CAUSE_WDOG = 1;
	localparam int CAUSE_DROP = 2;
	localparam int CAUSE_ILL = 3;
	localparam int CAUSE_USB = 4;
	localparam int CAUSE_POR = 5;
	localparam int CAUSE_W = 6;
	localparam logic [CAUSE_W-1:0] CAUSE_RST = 6'h20;

	// Synchroniser reset value: pin idles high, others low
	localparam logic [2:0] SYNC_RST = 3'h1;

	typedef enum logic [1:0] {
		ST_POR = 2'b00,
		ST_HOLD = 2'b01,
		ST_RUN = 2'b10
	} seq_state_t;

	typedef struct packed {
		logic [12:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic valid;
		logic [12:0] addr;
	} fetch_t;

endpackage

// ===== hdl/pin_sync.sv
// Purpose: two-stage synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels, no pulse shorter than two clocks matters
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Levels
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;

	// One pair of flops per bit
	for (genvar b = 0; b < WIDTH; b++) begin : g_bit
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				meta_q[b] <= RST_VAL[b];
				sync_o[b] <= RST_VAL[b];
			end else begin
				meta_q[b] <= async_i[b];
				sync_o[b] <= meta_q[b];
			end
		end
	end

endmodule
`default_nettype wire

// ===== hdl/mcu_reset_sequencer.sv
// Purpose: combine reset sources into the core reset and drive the reset pin pulldown
// Assumes: rst_n_i is the power-on reset; clock runs once the oscillator is active
// Notes: cause flags survive the core reset, they are cleared only by power-on (which loads the POR flag) or by writing ones to them
//
// Functional notes
// - Core reset comes from power-up, pin, watchdog, supply drop, illegal fetch, USB.
// - Any reset aborts the core at once and reinitialises its control state.
// - After power-up hold reset 4064 bus clocks for oscillator settling.
// - Other sources still active after the count keep reset asserted.
// - Pin still low after the count keeps reset until it rises.
// - Reset lasts as long as the pin is low, released after it rises.
// - An external pin reset drives the core and peripheral reset; here only core_rst_o is driven.
// - Pulldown only for watchdog, supply drop, illegal fetch; max(source, 3-4 clocks); here the source plus a 3-clock tail.
// - No pulldown while the pin is already held low from outside.
// - Power-on never turns the pulldown on.
// - SE0 over 4 bit times sets the bus reset flag and resets.
// - With the watchdog option, an unserviced period causes reset.
// - Writing zero to the clear bit at 1FF0 restarts the watchdog.
// - The service register reads as zero; clear bit resets to zero.
// - Watchdog pulldown time is resolved to the same 4-clock minimum.
// - On leaving reset set the interrupt mask and fetch the top vector; here only the vec_fetch_o strobe is given, no interrupt mask.
// - Fetch outside 1000-1FFF and 0080-012F resets with pulldown.
// - With the supply option, a supply drop resets and pulls the pin.
`timescale 1ns/10ps
`default_nettype none
module mcu_reset_sequencer import rst_seq_pkg::*; #(
	parameter int WDOG_CYCLES = 65536,
	parameter bit WDOG_EN = 1'b1,
	parameter bit SUPPLY_DROP_EN = 1'b1
) (
	// Clock and power-on reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Open-drain reset pin
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_o,
	// Analog and USB detectors
	input wire logic supply_low_i,
	input wire logic usb_se0_i,
	// Core side
	input wire fetch_t fetch_i,
	output logic core_rst_o,
	output logic vec_fetch_o,
	output logic bus_reset_flag_o,
	// Register port
	input wire reg_req_t req_i,
	output logic [7:0] rd_data_o
);

	localparam int WC_W = $clog2(WDOG_CYCLES);
	localparam int SC_W = $clog2(SE0_CYCLES + 1);
	localparam logic [WC_W-1:0] WDOG_LAST = WC_W'(WDOG_CYCLES - 1);
	localparam logic [SC_W-1:0] SE0_LAST = SC_W'(SE0_CYCLES);
	localparam logic [11:0] POR_LAST = 12'(POR_CYCLES - 1);

	seq_state_t st_q, st_d;
	logic [2:0] sync_w;
	logic pin_s, drop_s, se0_s;
	logic [11:0] por_cnt_q;
	logic [WC_W-1:0] wdog_cnt_q;
	logic [SC_W-1:0] se0_cnt_q;
	logic [2:0] pd_cnt_q, pd_cnt_d;
	logic [2:0] pd_hist_q;
	logic [CAUSE_W-1:0] cause_q, cause_set, cause_clr;
	logic run, ext_low, drop_lvl, usb_hit, illegal, in_rom, in_ram;
	logic service, wdog_to, pd_src, pd_start, any_src, por_done;
	logic cause_wr, cause_rd;

	// Pin, supply and SE0 levels are asynchronous to the bus clock
	pin_sync #(
		.WIDTH(3),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i({usb_se0_i, supply_low_i, rst_pin_i}),
		.sync_o(sync_w)
	);

	assign pin_s = sync_w[0];
	assign drop_s = sync_w[1];
	assign se0_s = sync_w[2];
	assign run = (st_q == ST_RUN);

	// Our own pulldown reads back as a low pin; mask it plus the sync lag
	assign ext_low = !pin_s && !rst_pin_oe_o && (pd_hist_q == 3'h0);
	assign drop_lvl = SUPPLY_DROP_EN && drop_s;
	assign usb_hit = se0_s && (se0_cnt_q == SE0_LAST);

	// Illegal fetch decode, only while the core runs
	assign in_rom = (fetch_i.addr >= ROM_LO);
	assign in_ram = (fetch_i.addr >= RAM_LO) && (fetch_i.addr <= RAM_HI);
	assign illegal = run && fetch_i.valid && !in_rom && !in_ram;

	// Watchdog service and timeout
	assign service = req_i.wr && (req_i.addr == WDOG_SERVICE_ADDR)
		&& !req_i.wdata[WDOG_CLR_BIT];
	assign wdog_to = WDOG_EN && run && (wdog_cnt_q == WDOG_LAST);

	// Pulldown sources; power-on and the pin itself are not among them
	assign pd_src = wdog_to || drop_lvl || illegal;
	assign pd_start = pd_src && !ext_low;
	assign pd_cnt_d = pd_start ? PULL_CYCLES
		: (pd_cnt_q != 3'h0) ? pd_cnt_q - 3'h1 : 3'h0;

	// Everything that holds the core in reset besides the power-on count
	assign any_src = ext_low || drop_lvl || usb_hit || pd_start || rst_pin_oe_o;
	assign por_done = (por_cnt_q == POR_LAST);

	// Sequencer: power-on count, then hold while any source stays active
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_POR: begin
				if (por_done) begin
					st_d = any_src ? ST_HOLD : ST_RUN;
				end
			end
			ST_HOLD: begin
				if (!any_src) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (any_src) begin
					st_d = ST_HOLD;
				end
			end
			default: begin
				st_d = ST_POR;
			end
		endcase
	end

	// Cause flags: set wins over a software clear in the same cycle
	assign cause_wr = req_i.wr && (req_i.addr == CAUSE_ADDR);
	assign cause_rd = req_i.rd && (req_i.addr == CAUSE_ADDR);
	assign cause_clr = cause_wr ? req_i.wdata[CAUSE_W-1:0] : '0;
	assign cause_set = {1'b0, usb_hit, illegal, drop_lvl, wdog_to, ext_low};

	// State and power-on counter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= ST_POR;
			por_cnt_q <= 12'h000;
		end else begin
			st_q <= st_d;
			por_cnt_q <= (st_q == ST_POR) ? por_cnt_q + 12'h001 : por_cnt_q;
		end
	end

	// Watchdog counter restarts on service and while the core is held
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wdog_cnt_q <= '0;
		end else if (service || !run || wdog_to) begin
			wdog_cnt_q <= '0;
		end else begin
			wdog_cnt_q <= wdog_cnt_q + WC_W'(1);
		end
	end

	// SE0 length counter, saturating at the detect threshold
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			se0_cnt_q <= '0;
		end else if (!se0_s) begin
			se0_cnt_q <= '0;
		end else if (se0_cnt_q != SE0_LAST) begin
			se0_cnt_q <= se0_cnt_q + SC_W'(1);
		end
	end

	// Pulldown stretcher and its read-back mask
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pd_cnt_q <= 3'h0;
			pd_hist_q <= 3'h0;
			rst_pin_oe_o <= 1'b0;
			rst_pin_o <= 1'b0;
		end else begin
			pd_cnt_q <= pd_cnt_d;
			pd_hist_q <= {pd_hist_q[1:0], rst_pin_oe_o};
			rst_pin_oe_o <= (pd_cnt_d != 3'h0);
			rst_pin_o <= 1'b0;
		end
	end

	// Core reset and vector fetch strobe
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_rst_o <= 1'b1;
			vec_fetch_o <= 1'b0;
		end else begin
			core_rst_o <= (st_d != ST_RUN);
			vec_fetch_o <= (st_d == ST_RUN) && !run;
		end
	end

	// Cause register and read port; the service register reads as zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cause_q <= CAUSE_RST;
			bus_reset_flag_o <= 1'b0;
			rd_data_o <= 8'h00;
		end else begin
			cause_q <= (cause_q & ~cause_clr) | cause_set;
			bus_reset_flag_o <= cause_set[CAUSE_USB] || (cause_q[CAUSE_USB]
				&& !cause_clr[CAUSE_USB]);
			rd_data_o <= cause_rd ? {2'b00, cause_q} : 8'h00;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	por_hold_a: assert property (
		(st_q == ST_POR && !por_done) |=> core_rst_o)
		else $error("core reset released during power-on count");

	other_hold_a: assert property (
		(st_q != ST_RUN && any_src) |=> core_rst_o)
		else $error("core reset released with a source active");

	pin_hold_a: assert property (
		ext_low |=> core_rst_o && cause_q[CAUSE_PIN])
		else $error("external pin low did not hold reset");

	pd_min_a: assert property (
		$rose(rst_pin_oe_o) |-> rst_pin_oe_o[*4])
		else $error("pulldown shorter than four clocks");

	pd_cause_a: assert property (
		$rose(rst_pin_oe_o) |-> $past(pd_src) && !$past(ext_low))
		else $error("pulldown started without an allowed source");

	usb_flag_a: assert property (
		usb_hit |=> bus_reset_flag_o && core_rst_o)
		else $error("USB bus reset not flagged");

	// An outside low in the same cycle legally suppresses our pulldown
	wdog_fire_a: assert property (
		wdog_to |=> (rst_pin_oe_o || $past(ext_low)) && core_rst_o && cause_q[CAUSE_WDOG])
		else $error("watchdog timeout did not reset");

	wdog_clear_a: assert property (
		(service && run) |=> wdog_cnt_q == '0)
		else $error("watchdog service did not restart the count");

	svc_read_a: assert property (
		(req_i.rd && req_i.addr == WDOG_SERVICE_ADDR) |=> rd_data_o == 8'h00)
		else $error("watchdog service register read nonzero");

	vec_start_a: assert property (
		vec_fetch_o |-> !core_rst_o && $past(core_rst_o) ##1 !vec_fetch_o)
		else $error("vector fetch strobe misplaced");

	illegal_a: assert property (
		illegal |=> (rst_pin_oe_o || $past(ext_low)) && core_rst_o)
		else $error("illegal fetch did not reset");

endmodule
`default_nettype wire

// ===== testbench/board_model.sv
// Purpose: board reset circuit and upstream host at the far side
// Assumes: passive pull-up on the reset pin
// Notes: pin level is a wired-AND of the pulldown and the outside switch
`timescale 1ns/10ps
`default_nettype none
module board_model (
	// Requests from the bench
	input wire logic ext_low_i,
	input wire logic se0_i,
	// Device pad and host line
	input wire logic rst_pin_o_i,
	input wire logic rst_pin_oe_i,
	output logic rst_pin_lvl_o,
	output logic usb_se0_o
);
	// Pull-up only wins while nobody pulls low, so a released pin never holds a stale low
	assign rst_pin_lvl_o = ((rst_pin_oe_i & ~rst_pin_o_i) | ext_low_i) ? 1'b0 : 1'b1;
	// Host holds SE0 exactly as long as asked
	assign usb_se0_o = se0_i;
endmodule
`default_nettype wire

// ===== testbench/mcu_reset_sequencer_tb_top.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: watchdog period shortened to WDOG_N
// Notes: every scenario ends with the core running; all but t_por also start with it running
`timescale 1ns/10ps
`default_nettype none
module mcu_reset_sequencer_tb_top import rst_seq_pkg::*;;
	localparam int WDOG_N = 512;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ext_low = 1'b0;
	logic se0 = 1'b0;
	logic supply_low = 1'b0;
	fetch_t fetch = '0;
	reg_req_t req = '0;
	logic pin_lvl, usb_se0, rst_pin_o, rst_pin_oe_o, core_rst_o, vec_fetch_o, bus_reset_flag_o;
	logic [7:0] rd_data_o;
	int error_cnt = 0;
	int check_count = 0;
	int n, oe_n;

	// Block and its far side
	mcu_reset_sequencer #(.WDOG_CYCLES(WDOG_N), .WDOG_EN(1'b1), .SUPPLY_DROP_EN(1'b1))
	u_mcu_reset_sequencer (.clk_i(clk_i), .rst_n_i(rst_n_i), .rst_pin_i(pin_lvl),
		.rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o), .supply_low_i(supply_low),
		.usb_se0_i(usb_se0), .fetch_i(fetch), .core_rst_o(core_rst_o),
		.vec_fetch_o(vec_fetch_o), .bus_reset_flag_o(bus_reset_flag_o),
		.req_i(req), .rd_data_o(rd_data_o));
	board_model u_board_model (.ext_low_i(ext_low), .se0_i(se0), .rst_pin_o_i(rst_pin_o),
		.rst_pin_oe_i(rst_pin_oe_o), .rst_pin_lvl_o(pin_lvl), .usb_se0_o(usb_se0));

	// 40 MHz clock
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_i);
		req.wr <= 1'b0;
	endtask

	// Read data is looked at only in the cycle after the strobe
	task automatic rd(input logic [12:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_i);
		req.rd <= 1'b0;
		#1 chk(rd_data_o, exp);
	endtask

	task automatic cause(input logic [7:0] exp);
		rd(CAUSE_ADDR, exp);
		wr(CAUSE_ADDR, 8'h3F);
		rd(CAUSE_ADDR, 8'h00);
	endtask

	task automatic wait_hi(input int lim);
		#1;
		n = 0;
		while (core_rst_o !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			#1 n++;
		end
		chk(core_rst_o, 1'b1);
	endtask

	// Counts reset and pulldown cycles until the core runs again
	task automatic wait_run();
		#1;
		oe_n = 0;
		n = 0;
		while (core_rst_o === 1'b1 && n < 5000) begin
			oe_n += rst_pin_oe_o;
			@(posedge clk_i);
			#1 n++;
		end
		chk(vec_fetch_o, 1'b1);
		@(posedge clk_i);
		#1 chk(vec_fetch_o, 1'b0);
	endtask

	task automatic t_por();
		repeat (5) @(posedge clk_i);
		chk(core_rst_o, 1'b1);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		#1 wait_run();
		chk(n >= POR_CYCLES - 2 && n <= POR_CYCLES + 2, 1'b1);
		chk(oe_n, 0);
		chk(rst_pin_o, 1'b0);
		rd(WDOG_SERVICE_ADDR, 8'h00);
		rd(13'h0ABC, 8'h00);
		cause(8'h20);
	endtask

	task automatic t_pin();
		@(posedge clk_i);
		ext_low <= 1'b1;
		wait_hi(6);
		repeat (4) @(posedge clk_i);
		#1 chk(core_rst_o, 1'b1);
		@(posedge clk_i);
		ext_low <= 1'b0;
		wait_run();
		chk(oe_n, 0);
		chk(n <= 4, 1'b1);
		cause(8'h01);
	endtask

	task automatic t_fetch();
		logic [12:0] a[7] = '{13'h0080, 13'h012F, 13'h1000, 13'h1FFF, 13'h007F, 13'h0130, 13'h0FFF};
		for (int i = 0; i < 7; i++) begin
			@(posedge clk_i);
			fetch <= '{valid: 1'b1, addr: a[i]};
			@(posedge clk_i);
			fetch.valid <= 1'b0;
			#1 chk(core_rst_o, i >= 4);
			if (i >= 4) begin
				wait_run();
				chk(oe_n, 4);
				cause(8'h08);
			end
		end
	endtask

	task automatic t_supply();
		@(posedge clk_i);
		supply_low <= 1'b1;
		fork
			begin
				repeat (10) @(posedge clk_i);
				supply_low <= 1'b0;
			end
		join_none
		wait_hi(6);
		wait_run();
		// Ten synchronised drop cycles, then the three-cycle stretch tail
		chk(oe_n, 13);
		cause(8'h04);
	endtask

	task automatic t_usb();
		@(posedge clk_i);
		se0 <= 1'b1;
		repeat (50) @(posedge clk_i);
		se0 <= 1'b0;
		#1 chk(core_rst_o, 1'b0);
		@(posedge clk_i);
		se0 <= 1'b1;
		fork
			begin
				repeat (120) @(posedge clk_i);
				se0 <= 1'b0;
			end
		join_none
		wait_hi(130);
		chk(bus_reset_flag_o, 1'b1);
		wait_run();
		chk(oe_n, 0);
		cause(8'h10);
		chk(bus_reset_flag_o, 1'b0);
	endtask

	// A written one must not restart the count, so expiry comes early
	task automatic t_wdog();
		repeat (4) begin
			wr(WDOG_SERVICE_ADDR, 8'h00);
			repeat (200) @(posedge clk_i);
			#1 chk(core_rst_o, 1'b0);
		end
		wr(WDOG_SERVICE_ADDR, 8'h01);
		wait_hi(WDOG_N);
		chk(n > 290 && n < 320, 1'b1);
		wait_run();
		chk(oe_n, 4);
		cause(8'h02);
	endtask

	task automatic t_hold();
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		ext_low <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (POR_CYCLES + 20) @(posedge clk_i);
		#1 chk(core_rst_o, 1'b1);
		chk(rst_pin_oe_o, 1'b0);
		@(posedge clk_i);
		ext_low <= 1'b0;
		wait_run();
		chk(n <= 4, 1'b1);
	endtask

	task automatic results();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		t_por();
		t_pin();
		t_fetch();
		t_supply();
		t_usb();
		t_wdog();
		t_hold();
		results();
	end

	// Hang guard, well past the expected run of about 9600 cycles
	initial begin
		repeat (30000) @(posedge clk_i);
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire
